// File: bench/ddrct_dev_model.sv
`timescale 1ns/1ps
module ddrct_dev_model
    import ddrct_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Pins from the controller
    input wire ddrct_pins_t dram,
    // Spacing faults seen and applied extended mode
    output logic [7:0] viol,
    output logic [13:0] ext_mode
);
    int cyc;
    int last_act;
    int last_col;
    int last_mrs;

    // Command decode; gaps kept in cycles, since the pins move only on edges
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cyc = 0;
            last_act = -100;
            last_col = -100;
            last_mrs = -100;
            viol = 8'h00;
            ext_mode = 14'h0000;
        end else begin
            cyc++;
            if (dram.cmd_n != PINS_NOP && cyc - last_mrs < MRD_NCK) viol++;
            case (dram.cmd_n)
                PINS_ACT: begin
                    if (cyc - last_act < ACT_MIN_NCK) viol++;
                    last_act = cyc;
                end
                PINS_RD, PINS_WR: begin
                    if (cyc - last_col < CCD_NCK) viol++;
                    last_col = cyc;
                end
                PINS_MRS: begin
                    last_mrs = cyc;
                    // Termination and drive take effect at once, inside the limit
                    if (dram.ba == 2'h1) ext_mode = dram.addr;
                end
                default: ;
            endcase
        end
    end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ddrct_pkg::*;
    // Write latency al+cl-1 with al 0, cl 5; burst of four is two clocks
    localparam int WL = 4;
    localparam int WTR_EXP = WL + 2 + 1;
    localparam int WRP_EXP = WL + 2 + 1;
    localparam int RTP_EXP = 2;
    // Refresh time plus 10 ns, rounded up to whole clocks
    localparam int XSNR_EXP = (RFC_PS + XSNR_EXTRA_PS + CLK_PS - 1) / CLK_PS;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    ddrct_cfg_t cfg = '{1'b0, 1'b0, 3'h0, 3'h5, 4'h3, 4'h1, 1'b0};
    logic req_valid = 1'b0;
    ddrct_req_t req = '{CMD_NOP, 2'h0, 14'h0000};
    logic req_ready;
    logic odt_req = 1'b0;
    ddrct_pins_t dram;
    logic [7:0] viol;
    logic dram_clk_run;
    logic in_sref;
    logic in_pdown;
    logic term_sync_ok;
    logic [13:0] ext_mode;
    int cyc = 0;
    int last_t = 0;
    int prev_t = 0;
    int bad_count = 0;
    int cmp_count = 0;

    always #10 clk_sys = ~clk_sys;

    ddrct_ctrl u_dut (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .odt_req(odt_req), .dram(dram),
        .dram_clk_run(dram_clk_run), .in_sref(in_sref), .in_pdown(in_pdown),
        .term_sync_ok(term_sync_ok));

    ddrct_dev_model u_dev (.clk_sys(clk_sys), .nrst(nrst), .dram(dram), .viol(viol),
        .ext_mode(ext_mode));

    // Edge stamps of commands seen on the pins
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (dram.cmd_n !== PINS_NOP) begin
            prev_t <= last_t;
            last_t <= cyc;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Hold the request until ready is seen high at a falling edge, then through the next rising edge
    task automatic issue(input ddrct_cmd_t c, input logic [1:0] b, input logic [13:0] a);
        int n;
        n = 0;
        req_valid = 1'b1;
        req = '{c, b, a};
        forever begin
            @(negedge clk_sys);
            n++;
            if (req_ready === 1'b1 || n > 400) break;
        end
        @(posedge clk_sys);
        #1;
        check(n <= 400, 1'b1, "request never taken");
    endtask

    // Two requests back to back; the pin gap must reach the least spacing
    task automatic pair(input ddrct_cmd_t c1, input logic [1:0] b1, input ddrct_cmd_t c2,
        input logic [1:0] b2, input int exp, input string name);
        issue(c1, b1, 14'h0000);
        issue(c2, b2, 14'h0000);
        req_valid = 1'b0;
        @(posedge clk_sys);
        #1;
        check(last_t - prev_t >= exp, 1'b1, name);
        $display("test %s done", name);
    endtask

    // Active power-down, slow exit picked by mode bit 12; additive latency is zero
    task automatic t_power_down();
        int t0;
        issue(CMD_MRS, 2'h1, 14'h0044);
        issue(CMD_MRS, 2'h0, 14'h1000);
        check(ext_mode, 14'h0044, "extended mode not applied");
        issue(CMD_ACT, 2'h2, 14'h0000);
        issue(CMD_PDE, 2'h0, 14'h0000);
        check(in_pdown, 1'b1, "power-down not entered");
        issue(CMD_PDX, 2'h0, 14'h0000);
        t0 = cyc;
        check(dram.cke, 1'b1, "clock enable not raised");
        check(term_sync_ok, 1'b0, "termination sync at exit");
        odt_req = 1'b1;
        @(posedge clk_sys);
        #1;
        check(dram.odt, 1'b0, "termination moved too early");
        issue(CMD_RD, 2'h2, 14'h0000);
        check(cyc - t0 >= XARDS_800_NCK, 1'b1, "slow exit to read");
        check(term_sync_ok, 1'b1, "termination sync never back");
        check(dram.odt, 1'b1, "termination not applied");
        $display("test power-down done");
    endtask

    // Self refresh with the device clock stopped, then both exit gaps
    task automatic t_self_refresh();
        int t0;
        issue(CMD_PRE, 2'h2, 14'h0000);
        issue(CMD_SRE, 2'h0, 14'h0000);
        check(in_sref, 1'b1, "self refresh not entered");
        check(dram.cke, 1'b0, "clock enable not dropped");
        check(dram_clk_run, 1'b1, "clock stopped with enable");
        @(posedge clk_sys);
        #1;
        check(dram_clk_run, 1'b1, "clock stopped too soon");
        @(posedge clk_sys);
        #1;
        check(dram_clk_run, 1'b0, "clock kept running");
        issue(CMD_SRX, 2'h0, 14'h0000);
        t0 = cyc;
        check(dram.cke && !in_sref && dram_clk_run, 1'b1, "self refresh not left");
        issue(CMD_ACT, 2'h3, 14'h0000);
        check(cyc - t0 >= XSNR_EXP, 1'b1, "non-read too soon after exit");
        issue(CMD_RD, 2'h3, 14'h0000);
        check(cyc - t0 >= XSRD_NCK, 1'b1, "read too soon after exit");
        req_valid = 1'b0;
        $display("test self refresh done");
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        @(posedge clk_sys);
        #1;
        pair(CMD_MRS, 2'h0, CMD_MRS, 2'h1, MRD_NCK, "mode set spacing");
        pair(CMD_ACT, 2'h0, CMD_ACT, 2'h1, 2, "activate spacing");
        pair(CMD_RD, 2'h0, CMD_RD, 2'h1, 2, "column spacing");
        pair(CMD_WR, 2'h0, CMD_RD, 2'h0, WTR_EXP, "write to read");
        pair(CMD_WR, 2'h1, CMD_PRE, 2'h1, WRP_EXP, "write recovery");
        pair(CMD_RD, 2'h0, CMD_PRE, 2'h0, RTP_EXP, "read to precharge");
        t_power_down();
        t_self_refresh();
        check(viol, 8'h00, "spacing fault at device pins");
        end_sim();
    end
endmodule

// File: core/ddrct_ctrl.sv
`timescale 1ns/1ps
module ddrct_ctrl
    import ddrct_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Device configuration as programmed
    input wire ddrct_cfg_t cfg,
    // Command request
    input wire logic req_valid,
    input wire ddrct_req_t req,
    output logic req_ready,
    // Termination request level
    input wire logic odt_req,
    // Device pins
    output ddrct_pins_t dram,
    output logic dram_clk_run,
    // Status
    output logic in_sref,
    output logic in_pdown,
    output logic term_sync_ok
);
    typedef enum logic [1:0] {ST_ON, ST_SREF, ST_PDN} ddrct_state_t;

    ddrct_state_t state_q;
    ddrct_state_t state_d;
    ddrct_pins_t pins_q;
    ddrct_pins_t pins_d;
    logic [NBANK-1:0] open_q;
    logic [NBANK-1:0] open_d;
    logic [1:0] faw_ptr_q;
    logic slow_exit_q;
    logic active_pd_q;
    logic clk_run_q;
    ddrct_cnt_t odt_age_q;

    // Configuration-derived gaps
    ddrct_cnt_t burst_half, wl, rrd, faw, wr_pre_gap, wtr_gap, rd_pre_gap;
    ddrct_cnt_t dal_gap, rdap_gap, trp, xp, xard, xards, anpd, axpd;

    assign burst_half = cfg.bl8 ? BL8_HALF : BL4_HALF;
    assign wl = ddrct_cnt_t'(cfg.al) + ddrct_cnt_t'(cfg.cl) - 8'h01;
    assign trp = ddrct_cnt_t'(cfg.trp);
    assign rrd = cfg.page_2kb ? RRD_2K_CYC : RRD_1K_CYC;
    assign faw = cfg.page_2kb ? FAW_2K_CYC : FAW_1K_CYC;
    assign wr_pre_gap = wl + burst_half + WR_CYC;
    assign wtr_gap = wl + burst_half + WTR_CYC;
    // Read to precharge is additive latency plus the later of half burst and the internal read gap
    assign rd_pre_gap = ddrct_cnt_t'(cfg.al)
        + ((burst_half > RTP_CYC) ? burst_half : RTP_CYC);
    assign dal_gap = wl + burst_half + ddrct_cnt_t'(cfg.wr) + trp;
    assign rdap_gap = rd_pre_gap + trp;
    assign xp = ddrct_cnt_t'(cfg.grade_1066 ? XP_1066_NCK : XP_800_NCK);
    assign xard = ddrct_cnt_t'(cfg.grade_1066 ? XARD_1066_NCK : XARD_800_NCK);
    assign xards = ddrct_cnt_t'(cfg.grade_1066 ? XARDS_1066_NCK : XARDS_800_NCK)
        - ddrct_cnt_t'(cfg.al);
    assign anpd = ddrct_cnt_t'(cfg.grade_1066 ? ANPD_1066_NCK : ANPD_800_NCK);
    assign axpd = ddrct_cnt_t'(cfg.grade_1066 ? AXPD_1066_NCK : AXPD_800_NCK);

    // Command decode
    logic issue, iss_act, iss_rd, iss_wr, iss_pre, iss_ref, iss_mrs;
    logic iss_sre, iss_srx, iss_pde, iss_pdx, iss_col, iss_nonrd, pre_all, ap;
    logic cmd_ok;

    assign req_ready = cmd_ok;
    assign issue = req_valid && cmd_ok;
    assign iss_act = issue && req.cmd == CMD_ACT;
    assign iss_rd = issue && req.cmd == CMD_RD;
    assign iss_wr = issue && req.cmd == CMD_WR;
    assign iss_pre = issue && req.cmd == CMD_PRE;
    assign iss_ref = issue && req.cmd == CMD_REF;
    assign iss_mrs = issue && req.cmd == CMD_MRS;
    assign iss_sre = issue && req.cmd == CMD_SRE;
    assign iss_srx = issue && req.cmd == CMD_SRX;
    assign iss_pde = issue && req.cmd == CMD_PDE;
    assign iss_pdx = issue && req.cmd == CMD_PDX;
    assign iss_col = iss_rd || iss_wr;
    assign iss_nonrd = issue && req.cmd != CMD_NOP && req.cmd != CMD_RD;
    assign pre_all = req.addr[AP_BIT];
    assign ap = req.addr[AP_BIT];

    // Global gap timers
    logic act_rdy, col_rdy, rd_rdy, nr_rdy, cke_rdy, hold_rdy;
    ddrct_cnt_t nr_gap, rd_gap;
    logic nr_load, rd_load;

    // Non-read gate: mode set, refresh and both exits
    assign nr_load = iss_mrs || iss_ref || iss_srx || iss_pdx;
    assign nr_gap = iss_mrs ? ddrct_cnt_t'(MRD_NCK)
        : iss_ref ? RFC_CYC
        : iss_srx ? XSNR_CYC
        : xp;
    // Read gate: the exit from active power-down depends on mode bit 12
    assign rd_load = nr_load || iss_wr;
    assign rd_gap = iss_wr ? wtr_gap
        : iss_mrs ? ddrct_cnt_t'(MRD_NCK)
        : iss_ref ? RFC_CYC
        : iss_srx ? ddrct_cnt_t'(XSRD_NCK)
        : !active_pd_q ? xp
        : slow_exit_q ? xards : xard;

    ddrct_gap_timer u_act (.clk_sys(clk_sys), .nrst(nrst), .load(iss_act), .gap(rrd),
        .ready(act_rdy));
    ddrct_gap_timer u_col (.clk_sys(clk_sys), .nrst(nrst), .load(iss_col),
        .gap(ddrct_cnt_t'(CCD_NCK)), .ready(col_rdy));
    ddrct_gap_timer u_rd (.clk_sys(clk_sys), .nrst(nrst), .load(rd_load), .gap(rd_gap),
        .ready(rd_rdy));
    ddrct_gap_timer u_nr (.clk_sys(clk_sys), .nrst(nrst), .load(nr_load), .gap(nr_gap),
        .ready(nr_rdy));
    ddrct_gap_timer u_cke (.clk_sys(clk_sys), .nrst(nrst),
        .load(iss_sre || iss_srx || iss_pde || iss_pdx),
        .gap(ddrct_cnt_t'(CKE_NCK)), .ready(cke_rdy));
    ddrct_gap_timer u_hold (.clk_sys(clk_sys), .nrst(nrst), .load(iss_sre),
        .gap(CLKHOLD_CYC), .ready(hold_rdy));
    ddrct_gap_timer u_axpd (.clk_sys(clk_sys), .nrst(nrst), .load(iss_pdx || iss_srx),
        .gap(axpd), .ready(term_sync_ok));

    // Per-bank and per-window timers
    logic [NBANK-1:0] pre_rdy, bact_rdy, faw_rdy;
    genvar gi;
    generate
        for (gi = 0; gi < NBANK; gi++) begin : g_bank
            logic hit, bact_load;
            ddrct_cnt_t bact_gap;
            assign hit = (req.ba == 2'(gi));
            // Precharge waits out write recovery or read-to-precharge
            ddrct_gap_timer u_pre (.clk_sys(clk_sys), .nrst(nrst),
                .load(iss_col && hit), .gap(iss_wr ? wr_pre_gap : rd_pre_gap),
                .ready(pre_rdy[gi]));
            // Next activate to this bank after precharge or auto-precharge
            assign bact_load = (iss_pre && (hit || pre_all)) || (iss_col && hit && ap);
            assign bact_gap = iss_pre ? trp : iss_wr ? dal_gap : rdap_gap;
            ddrct_gap_timer u_bact (.clk_sys(clk_sys), .nrst(nrst), .load(bact_load),
                .gap(bact_gap), .ready(bact_rdy[gi]));
            // One window slot per recent activate, taken in rotation
            ddrct_gap_timer u_faw (.clk_sys(clk_sys), .nrst(nrst),
                .load(iss_act && faw_ptr_q == 2'(gi)), .gap(faw),
                .ready(faw_rdy[gi]));
        end
    endgenerate

    // Admission per state; a refused command simply waits with ready low
    logic all_idle, pre_ok, bank_open;
    assign all_idle = (open_q == '0) && (&bact_rdy);
    assign bank_open = open_q[req.ba];
    assign pre_ok = pre_all ? (&pre_rdy) : pre_rdy[req.ba];

    always_comb begin
        cmd_ok = 1'b0;
        case (state_q)
            ST_ON: begin
                case (req.cmd)
                    CMD_NOP: cmd_ok = 1'b1;
                    CMD_ACT: cmd_ok = act_rdy && faw_rdy[faw_ptr_q] && bact_rdy[req.ba]
                        && !bank_open && nr_rdy;
                    CMD_RD: cmd_ok = col_rdy && rd_rdy && bank_open;
                    CMD_WR: cmd_ok = col_rdy && nr_rdy && bank_open;
                    CMD_PRE: cmd_ok = nr_rdy && pre_ok;
                    CMD_REF: cmd_ok = nr_rdy && all_idle;
                    CMD_MRS: cmd_ok = nr_rdy && all_idle;
                    CMD_SRE: cmd_ok = nr_rdy && all_idle && cke_rdy;
                    // Termination must not move on the edge that drops clock enable
                    CMD_PDE: cmd_ok = nr_rdy && cke_rdy && odt_age_q >= anpd
                        && (!term_sync_ok || odt_req == pins_q.odt);
                    default: cmd_ok = 1'b0;
                endcase
            end
            ST_SREF: cmd_ok = (req.cmd == CMD_NOP)
                || (req.cmd == CMD_SRX && cke_rdy && clk_run_q);
            ST_PDN: cmd_ok = (req.cmd == CMD_NOP) || (req.cmd == CMD_PDX && cke_rdy);
            default: cmd_ok = 1'b0;
        endcase
    end

    // Next pin state; power-down entry and both exits drive clock enable with a no-op, self-refresh entry with the refresh code
    logic [3:0] cmd_bits;
    always_comb begin
        case (req.cmd)
            CMD_ACT: cmd_bits = PINS_ACT;
            CMD_RD: cmd_bits = PINS_RD;
            CMD_WR: cmd_bits = PINS_WR;
            CMD_PRE: cmd_bits = PINS_PRE;
            CMD_REF: cmd_bits = PINS_REF;
            CMD_SRE: cmd_bits = PINS_REF;
            CMD_MRS: cmd_bits = PINS_MRS;
            default: cmd_bits = PINS_NOP;
        endcase
    end

    // Termination follows its request only while its timing is synchronous
    logic odt_next;
    assign odt_next = (state_q == ST_ON && term_sync_ok) ? odt_req : pins_q.odt;

    always_comb begin
        pins_d = pins_q;
        pins_d.odt = odt_next;
        pins_d.cmd_n = PINS_NOP;
        if (issue) begin
            pins_d.cmd_n = cmd_bits;
            pins_d.ba = req.ba;
            pins_d.addr = req.addr;
        end
        if (iss_sre || iss_pde) begin
            pins_d.cke = 1'b0;
        end else if (iss_srx || iss_pdx) begin
            pins_d.cke = 1'b1;
        end
    end

    // Bank open map and mode state
    assign open_d = iss_act ? (open_q | (4'h1 << req.ba))
        : (iss_pre && pre_all) ? '0
        : (iss_pre || (iss_col && ap)) ? (open_q & ~(4'h1 << req.ba))
        : open_q;
    assign state_d = (iss_sre) ? ST_SREF : (iss_pde) ? ST_PDN
        : (iss_srx || iss_pdx) ? ST_ON : state_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_ON;
            open_q <= '0;
            faw_ptr_q <= 2'h0;
            pins_q <= '{cke: 1'b0, odt: 1'b0, cmd_n: PINS_NOP, ba: 2'h0, addr: 14'h0000};
        end else begin
            state_q <= state_d;
            open_q <= open_d;
            faw_ptr_q <= iss_act ? faw_ptr_q + 2'h1 : faw_ptr_q;
            pins_q <= pins_d;
        end
    end

    // Remember the exit style written to mode register 0 and the kind of power-down
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            slow_exit_q <= 1'b0;
            active_pd_q <= 1'b0;
        end else begin
            if (iss_mrs && req.ba == 2'h0) begin
                slow_exit_q <= req.addr[MR_PDX_SLOW_BIT];
            end
            if (iss_pde) begin
                active_pd_q <= |open_q;
            end
        end
    end

    // Age of the termination level, saturating
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            odt_age_q <= '0;
        end else if (odt_next != pins_q.odt) begin
            odt_age_q <= '0;
        end else if (odt_age_q != 8'hFF) begin
            odt_age_q <= odt_age_q + 8'h01;
        end
    end

    // Device clock keeps running past the clock-enable drop, then may stop;
    // it restarts as soon as an exit is wanted, before the exit is admitted
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clk_run_q <= 1'b1;
        end else if (state_q == ST_SREF && req_valid && req.cmd == CMD_SRX) begin
            clk_run_q <= 1'b1;
        end else if (state_q == ST_SREF && hold_rdy) begin
            clk_run_q <= 1'b0;
        end else if (state_q != ST_SREF) begin
            clk_run_q <= 1'b1;
        end
    end

    assign dram = pins_q;
    assign dram_clk_run = clk_run_q;
    assign in_sref = (state_q == ST_SREF);
    assign in_pdown = (state_q == ST_PDN);

    // Helper counters for checks
    ddrct_cnt_t since_srx_q, since_wr_q, since_rd_q;
    logic [1:0] rd_ba_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            since_srx_q <= 8'hFF;
            since_wr_q <= 8'hFF;
            since_rd_q <= 8'hFF;
            rd_ba_q <= 2'h0;
        end else begin
            since_srx_q <= iss_srx ? 8'h01 : (since_srx_q == 8'hFF) ? 8'hFF : since_srx_q + 8'h01;
            since_wr_q <= iss_wr ? 8'h01 : (since_wr_q == 8'hFF) ? 8'hFF : since_wr_q + 8'h01;
            since_rd_q <= iss_rd ? 8'h01 : (since_rd_q == 8'hFF) ? 8'hFF : since_rd_q + 8'h01;
            rd_ba_q <= iss_rd ? req.ba : rd_ba_q;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_cke_edge;
        $changed(dram.cke);
    endsequence
    sequence s_cke_hold;
        $stable(dram.cke) [*2];
    endsequence

    property p_act_gap;
        iss_act |=> !iss_act;
    endproperty
    a_act_gap: assert property (p_act_gap) else $error("activates too close");
    property p_faw;
        iss_act |-> faw_rdy[faw_ptr_q];
    endproperty
    a_faw: assert property (p_faw) else $error("fifth activate in window");
    property p_col_gap;
        iss_col |=> !iss_col;
    endproperty
    a_col_gap: assert property (p_col_gap) else $error("column commands too close");
    property p_wtr;
        iss_rd |-> since_wr_q >= wtr_gap;
    endproperty
    a_wtr: assert property (p_wtr) else $error("read too soon after write");
    property p_rtp;
        iss_pre && (pre_all || req.ba == rd_ba_q) |-> since_rd_q >= rd_pre_gap;
    endproperty
    a_rtp: assert property (p_rtp) else $error("precharge too soon after read");
    property p_cke_pulse;
        s_cke_edge |=> s_cke_hold;
    endproperty
    a_cke_pulse: assert property (p_cke_pulse) else $error("clock enable pulse short");
    property p_xsnr;
        iss_srx |=> (!iss_nonrd) [*5];
    endproperty
    a_xsnr: assert property (p_xsnr) else $error("command too soon after sref exit");
    property p_xsrd;
        iss_rd |-> since_srx_q >= XSRD_NCK;
    endproperty
    a_xsrd: assert property (p_xsrd) else $error("read too soon after sref exit");
    property p_xp;
        iss_pdx |=> !iss_nonrd ##1 (!iss_nonrd || !cfg.grade_1066);
    endproperty
    a_xp: assert property (p_xp) else $error("command too soon after pd exit");
    property p_mrd;
        iss_mrs |=> !issue || req.cmd == CMD_NOP;
    endproperty
    a_mrd: assert property (p_mrd) else $error("command too soon after mode set");
    property p_anpd;
        iss_pde |-> odt_age_q >= anpd && pins_d.odt == pins_q.odt;
    endproperty
    a_anpd: assert property (p_anpd) else $error("termination not settled");
    property p_clk_hold;
        $fell(dram.cke) |-> dram_clk_run ##1 dram_clk_run;
    endproperty
    a_clk_hold: assert property (p_clk_hold) else $error("clock stopped early");
endmodule

// File: core/ddrct_gap_timer.sv
`timescale 1ns/1ps
module ddrct_gap_timer
    import ddrct_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Gap load, in cycles until the next allowed command
    input wire logic load,
    input wire ddrct_cnt_t gap,
    // Status
    output logic ready
);
    ddrct_cnt_t cnt_q;
    ddrct_cnt_t cnt_d;
    ddrct_cnt_t rem;
    ddrct_cnt_t dec;

    // A new gap only ever lengthens the wait, so sources never shorten each other
    assign rem = (gap == '0) ? '0 : gap - 8'h01;
    assign dec = (cnt_q == '0) ? '0 : cnt_q - 8'h01;
    assign cnt_d = (load && rem > dec) ? rem : dec;
    assign ready = (cnt_q == '0);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// File: core/ddrct_pkg.sv
package ddrct_pkg;

    // Clock period and counter width
    localparam int CLK_PS = 20000;
    localparam int CNT_W = 8;
    localparam int NBANK = 4;
    typedef logic [CNT_W-1:0] ddrct_cnt_t;

    // Least times round up, never below one cycle
    function automatic int ps2cyc(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int atleast(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // Times in picoseconds, as printed
    localparam int RRD_1K_PS = 7500;
    localparam int RRD_2K_PS = 10000;
    localparam int FAW_1K_PS = 35000;
    localparam int FAW_2K_PS = 45000;
    localparam int WR_PS = 15000;
    localparam int WTR_PS = 7500;
    localparam int RTP_PS = 7500;
    localparam int RFC_PS = 105000;
    localparam int XSNR_EXTRA_PS = 10000;
    localparam int IS_PS = 175;
    localparam int IH_PS = 250;

    // Times in clocks, as printed
    localparam int ACT_MIN_NCK = 2;
    localparam int CCD_NCK = 2;
    localparam int CKE_NCK = 3;
    localparam int XSRD_NCK = 200;
    localparam int XP_1066_NCK = 3;
    localparam int XP_800_NCK = 2;
    localparam int XARD_1066_NCK = 3;
    localparam int XARD_800_NCK = 2;
    localparam int XARDS_1066_NCK = 10;
    localparam int XARDS_800_NCK = 8;
    localparam int ANPD_1066_NCK = 4;
    localparam int ANPD_800_NCK = 3;
    localparam int AXPD_1066_NCK = 11;
    localparam int AXPD_800_NCK = 8;
    localparam int MRD_NCK = 2;

    // Derived cycle counts
    localparam ddrct_cnt_t RRD_1K_CYC = ddrct_cnt_t'(atleast(ps2cyc(RRD_1K_PS), ACT_MIN_NCK));
    localparam ddrct_cnt_t RRD_2K_CYC = ddrct_cnt_t'(atleast(ps2cyc(RRD_2K_PS), ACT_MIN_NCK));
    localparam ddrct_cnt_t FAW_1K_CYC = ddrct_cnt_t'(ps2cyc(FAW_1K_PS));
    localparam ddrct_cnt_t FAW_2K_CYC = ddrct_cnt_t'(ps2cyc(FAW_2K_PS));
    localparam ddrct_cnt_t WR_CYC = ddrct_cnt_t'(ps2cyc(WR_PS));
    localparam ddrct_cnt_t WTR_CYC = ddrct_cnt_t'(ps2cyc(WTR_PS));
    localparam ddrct_cnt_t RTP_CYC = ddrct_cnt_t'(ps2cyc(RTP_PS));
    localparam ddrct_cnt_t RFC_CYC = ddrct_cnt_t'(ps2cyc(RFC_PS));
    localparam ddrct_cnt_t XSNR_CYC = ddrct_cnt_t'(ps2cyc(RFC_PS + XSNR_EXTRA_PS));
    localparam ddrct_cnt_t CLKHOLD_CYC = ddrct_cnt_t'(ps2cyc(IS_PS + CLK_PS + IH_PS));

    // Mode register and address fields
    localparam int MR_PDX_SLOW_BIT = 12;
    localparam int AP_BIT = 10;
    localparam ddrct_cnt_t BL4_HALF = 8'h02;
    localparam ddrct_cnt_t BL8_HALF = 8'h04;

    // Pin codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] PINS_NOP = 4'h7;
    localparam logic [3:0] PINS_ACT = 4'h3;
    localparam logic [3:0] PINS_RD = 4'h5;
    localparam logic [3:0] PINS_WR = 4'h4;
    localparam logic [3:0] PINS_PRE = 4'h2;
    localparam logic [3:0] PINS_REF = 4'h1;
    localparam logic [3:0] PINS_MRS = 4'h0;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF,
        CMD_MRS, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX
    } ddrct_cmd_t;

    typedef struct packed {
        ddrct_cmd_t cmd;
        logic [1:0] ba;
        logic [13:0] addr;
    } ddrct_req_t;

    typedef struct packed {
        logic page_2kb;
        logic grade_1066;
        logic [2:0] al;
        logic [2:0] cl;
        logic [3:0] wr;
        logic [3:0] trp;
        logic bl8;
    } ddrct_cfg_t;

    typedef struct packed {
        logic cke;
        logic odt;
        logic [3:0] cmd_n;
        logic [1:0] ba;
        logic [13:0] addr;
    } ddrct_pins_t;

endpackage
